// file: core/cbd_pkg.sv
// Shared constants and types for the compare, decimal adjust and decrement execution block
package cbd_pkg;

  // ************************************************
  // Register map (byte addresses on APB)
  // ************************************************
  localparam logic [7:0] ACC_OFS = 8'h00;
  localparam logic [7:0] FLAGS_OFS = 8'h04;
  localparam logic [7:0] BANK_SEL_OFS = 8'h08;
  localparam logic [7:0] ISSUE_OFS = 8'h0c;
  localparam logic [7:0] EXEC_STAT_OFS = 8'h10;
  localparam logic [7:0] MEM_ADDR_OFS = 8'h14;
  localparam logic [7:0] MEM_DATA_OFS = 8'h18;

  // ************************************************
  // Field positions and reset values
  // ************************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;
  localparam int FLAG_W = 5;
  localparam int ISSUE_TWO_WORD_BIT = 16;
  localparam int ISSUE_DEST_BIT = 9;
  localparam int ISSUE_BANK_BIT = 8;
  localparam int STAT_SKIP_BIT = 2;
  localparam int STAT_UNKNOWN_BIT = 3;
  localparam int STAT_BUSY_BIT = 4;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [15:0] IR_RST = 16'h0000;

  // ************************************************
  // Opcodes and timing
  // ************************************************
  localparam logic [6:0] OP_COMPARE_SKIP_IF_LESS = 7'h30;
  localparam logic [15:0] OP_DECIMAL_ADJUST = 16'h0007;
  localparam logic [5:0] OP_DECREMENT_REGISTER = 6'h01;
  localparam logic [5:0] OP_DECREMENT_SKIP_IF_ZERO = 6'h0b;
  localparam logic [5:0] OP_DECREMENT_SKIP_IF_NONZERO = 6'h13;
  localparam logic [7:0] BCD_DIGIT_MAX = 8'h09;
  localparam logic [7:0] BCD_LOW_FIX = 8'h06;
  localparam logic [8:0] BCD_HIGH_FIX = 9'h060;
  localparam logic [7:0] OV_EDGE = 8'h80;
  localparam logic [2:0] NOP_ONE_CYCLE = 3'h3;
  localparam logic [2:0] NOP_TWO_CYCLES = 3'h7;
  localparam logic [1:0] CYCLES_ONE = 2'h1;
  localparam logic [1:0] CYCLES_TWO = 2'h2;
  localparam logic [1:0] CYCLES_THREE = 2'h3;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_Q1 = 6'b000010,
    ST_Q2 = 6'b000100,
    ST_Q3 = 6'b001000,
    ST_Q4 = 6'b010000,
    ST_NOP = 6'b100000
  } cbd_state_type;

  typedef enum logic [2:0] {
    K_NONE,
    K_CMP_LESS,
    K_DAW,
    K_DEC,
    K_DEC_SZ,
    K_DEC_SNZ
  } cbd_kind_type;

endpackage

// file: core/cbd_data_mem.sv
// Banked data memory with registered read data
`timescale 1ns/1ps
module cbd_data_mem #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  output logic [DW-1:0] rdata_out
);

  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  // No reset: contents are undefined until written, as in a real RAM
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_q[addr_in] <= wdata_in;
    end
    rdata_out <= mem_q[addr_in];
  end

endmodule

// file: core/cbd_exec_top.sv
// Execution engine for compare-skip, decimal adjust and decrement instructions, APB slave
// Functional notes
// - Compare-skip-if-less decodes from 0110000a plus address; flags untouched.
// - Compare skips only when register is unsigned-below the accumulator.
// - Taken skip discards next instruction and runs one no-operation cycle per word it holds.
// - Skip over a two-word instruction costs three cycles, extra cycles idle.
// - Compare bank bit zero forces access bank; one uses bank selection.
// - Decimal adjust adds 6 to low nibble when above 9 or digit carry.
// - Decimal adjust adds 6 to high nibble when above 9 or carry.
// - Decimal adjust changes only carry, leaving digit carry; carry may set, never clears.
// - Decimal adjust recognised only from opcode 0007, one word, one cycle.
// - Decrement writes result to accumulator if dest bit 0, else register.
// - Decrement updates carry, digit carry, negative, overflow and zero.
// - Decrement decodes from 000001 then dest, bank bit and address.
// - Decrement bank bit one uses bank selection, zero forces access bank.
// - Decrement-skip-if-nonzero skips when the result is nonzero.
`timescale 1ns/1ps
module cbd_exec_top #(
  parameter int BANK_W = 4,
  parameter logic [3:0] ACCESS_BANK = 4'h0
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic busy_out
);
  import cbd_pkg::*;

  localparam int AW = BANK_W + 8;

  // ************************************************
  // Decode helpers
  // ************************************************
  function automatic cbd_kind_type decode_kind(input logic [15:0] ir);
    if (ir[15:9] == OP_COMPARE_SKIP_IF_LESS) begin
      decode_kind = K_CMP_LESS;
    end else if (ir == OP_DECIMAL_ADJUST) begin
      decode_kind = K_DAW;
    end else if (ir[15:10] == OP_DECREMENT_REGISTER) begin
      decode_kind = K_DEC;
    end else if (ir[15:10] == OP_DECREMENT_SKIP_IF_ZERO) begin
      decode_kind = K_DEC_SZ;
    end else if (ir[15:10] == OP_DECREMENT_SKIP_IF_NONZERO) begin
      decode_kind = K_DEC_SNZ;
    end else begin
      decode_kind = K_NONE;
    end
  endfunction

  function automatic logic is_decrement(input cbd_kind_type k);
    is_decrement = (k == K_DEC) || (k == K_DEC_SZ) || (k == K_DEC_SNZ);
  endfunction

  // ************************************************
  // State
  // ************************************************
  cbd_state_type state_q, state_d;
  logic [15:0] ir_q, ir_d;
  logic two_word_q, two_word_d;
  logic [7:0] acc_q, acc_d;
  logic [4:0] flags_q, flags_d;
  logic [4:0] new_flags_q, new_flags_d;
  logic [BANK_W-1:0] bank_q, bank_d;
  logic [7:0] opnd_q, opnd_d;
  logic [7:0] res_q, res_d;
  logic skip_q, skip_d;
  logic [2:0] nop_left_q, nop_left_d;
  logic [1:0] last_cycles_q, last_cycles_d;
  logic last_skip_q, last_skip_d;
  logic unknown_q, unknown_d;
  logic [AW-1:0] mem_addr_q, mem_addr_d;
  logic idle_prev_q, idle_prev_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  logic busy_d;

  cbd_kind_type kind;
  logic [BANK_W-1:0] bank_eff;
  logic [AW-1:0] mem_a;
  logic mem_we;
  logic [7:0] mem_wd;
  logic [7:0] mem_rd;
  logic go;
  logic [8:0] daw_lo, daw_hi;
  logic [31:0] rd_mux;
  logic map_hit;

  assign kind = decode_kind(ir_q);
  // Bank bit one keeps the bank selection register, zero forces the access bank
  assign bank_eff = ir_q[ISSUE_BANK_BIT] ? bank_q : ACCESS_BANK[BANK_W-1:0];
  // Engine owns the memory port while busy; software address otherwise
  assign mem_a = (state_q == ST_IDLE) ? mem_addr_q : {bank_eff, ir_q[7:0]};
  // Access is serviced only once the engine has been idle for a full cycle,
  // so registered memory data no longer reflects an engine address
  assign go = psel_in && penable_in && !pready_out && (state_q == ST_IDLE) && idle_prev_q;

  cbd_data_mem #(
    .AW(AW),
    .DW(8)
  ) u_mem (
    .clk_in(clk_in),
    .we_in(mem_we),
    .addr_in(mem_a),
    .wdata_in(mem_wd),
    .rdata_out(mem_rd)
  );

  // ************************************************
  // Read mux
  // ************************************************
  always_comb begin
    map_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr_in)
      ACC_OFS: rd_mux[7:0] = acc_q;
      FLAGS_OFS: rd_mux[FLAG_W-1:0] = flags_q;
      BANK_SEL_OFS: rd_mux[BANK_W-1:0] = bank_q;
      ISSUE_OFS: rd_mux[ISSUE_TWO_WORD_BIT:0] = {two_word_q, ir_q};
      EXEC_STAT_OFS: begin
        rd_mux[1:0] = last_cycles_q;
        rd_mux[STAT_SKIP_BIT] = last_skip_q;
        rd_mux[STAT_UNKNOWN_BIT] = unknown_q;
        rd_mux[STAT_BUSY_BIT] = busy_out;
      end
      MEM_ADDR_OFS: rd_mux[AW-1:0] = mem_addr_q;
      MEM_DATA_OFS: rd_mux[7:0] = mem_rd;
      default: map_hit = 1'b0;
    endcase
  end

  // ************************************************
  // Next-state logic
  // ************************************************
  always_comb begin
    state_d = state_q;
    ir_d = ir_q;
    two_word_d = two_word_q;
    acc_d = acc_q;
    flags_d = flags_q;
    new_flags_d = new_flags_q;
    bank_d = bank_q;
    opnd_d = opnd_q;
    res_d = res_q;
    skip_d = skip_q;
    nop_left_d = nop_left_q;
    last_cycles_d = last_cycles_q;
    last_skip_d = last_skip_q;
    unknown_d = unknown_q;
    mem_addr_d = mem_addr_q;
    mem_we = 1'b0;
    mem_wd = pwdata_in[7:0];
    prdata_d = 32'h0000_0000;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    daw_lo = 9'h000;
    daw_hi = 9'h000;

    if (go) begin
      pready_d = 1'b1;
      pslverr_d = !map_hit;
      if (!pwrite_in) begin
        prdata_d = rd_mux;
      end else begin
        unique case (paddr_in)
          ACC_OFS: acc_d = pwdata_in[7:0];
          FLAGS_OFS: flags_d = pwdata_in[FLAG_W-1:0];
          BANK_SEL_OFS: bank_d = pwdata_in[BANK_W-1:0];
          ISSUE_OFS: begin
            ir_d = pwdata_in[15:0];
            two_word_d = pwdata_in[ISSUE_TWO_WORD_BIT];
            state_d = ST_Q1;
          end
          MEM_ADDR_OFS: mem_addr_d = pwdata_in[AW-1:0];
          MEM_DATA_OFS: mem_we = 1'b1;
          default: ;
        endcase
      end
    end

    unique case (state_q)
      ST_IDLE: ;
      ST_Q1: begin
        // Decode; operand address goes to the memory this quarter
        unknown_d = (kind == K_NONE);
        skip_d = 1'b0;
        state_d = ST_Q2;
      end
      ST_Q2: begin
        opnd_d = (kind == K_DAW) ? acc_q : mem_rd;
        state_d = ST_Q3;
      end
      ST_Q3: begin
        new_flags_d = flags_q;
        res_d = opnd_q;
        if (kind == K_CMP_LESS) begin
          skip_d = (opnd_q < acc_q);
        end else if (kind == K_DAW) begin
          // Low fix carries into the high digit, as a packed BCD sum needs
          daw_lo = {1'b0, opnd_q};
          if ((opnd_q[3:0] > BCD_DIGIT_MAX[3:0]) || flags_q[FLAG_DC]) begin
            daw_lo = {1'b0, opnd_q} + {1'b0, BCD_LOW_FIX};
          end
          daw_hi = daw_lo;
          if ((daw_lo[7:4] > BCD_DIGIT_MAX[3:0]) || flags_q[FLAG_C] || daw_lo[8]) begin
            daw_hi = daw_lo + BCD_HIGH_FIX;
          end
          res_d = daw_hi[7:0];
          new_flags_d[FLAG_C] = daw_hi[8] || daw_lo[8] || flags_q[FLAG_C];
        end else if (is_decrement(kind)) begin
          res_d = opnd_q - 8'h01;
          new_flags_d[FLAG_C] = (opnd_q != 8'h00);
          new_flags_d[FLAG_DC] = (opnd_q[3:0] != 4'h0);
          new_flags_d[FLAG_N] = res_d[7];
          new_flags_d[FLAG_Z] = (res_d == 8'h00);
          new_flags_d[FLAG_OV] = (opnd_q == OV_EDGE);
          if (kind == K_DEC_SZ) begin
            skip_d = (res_d == 8'h00);
          end else if (kind == K_DEC_SNZ) begin
            skip_d = (res_d != 8'h00);
          end
        end
        state_d = ST_Q4;
      end
      ST_Q4: begin
        if (kind == K_DAW) begin
          acc_d = res_q;
          flags_d = new_flags_q;
        end else if (is_decrement(kind)) begin
          if (ir_q[ISSUE_DEST_BIT]) begin
            mem_we = 1'b1;
            mem_wd = res_q;
          end else begin
            acc_d = res_q;
          end
          if (kind == K_DEC) begin
            flags_d = new_flags_q;
          end
        end
        last_skip_d = skip_q;
        if (skip_q) begin
          // Discarded word replaced by idle quarters; two words cost two cycles
          nop_left_d = two_word_q ? NOP_TWO_CYCLES : NOP_ONE_CYCLE;
          last_cycles_d = two_word_q ? CYCLES_THREE : CYCLES_TWO;
          state_d = ST_NOP;
        end else begin
          last_cycles_d = CYCLES_ONE;
          state_d = ST_IDLE;
        end
      end
      ST_NOP: begin
        nop_left_d = nop_left_q - 3'h1;
        if (nop_left_q == 3'h0) begin
          state_d = ST_IDLE;
        end
      end
    endcase
    busy_d = (state_d != ST_IDLE);
    idle_prev_d = (state_q == ST_IDLE);
  end

  // ************************************************
  // Registers
  // ************************************************
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= ST_IDLE;
      ir_q <= IR_RST;
      two_word_q <= 1'b0;
      acc_q <= ACC_RST;
      flags_q <= FLAGS_RST;
      new_flags_q <= FLAGS_RST;
      bank_q <= '0;
      opnd_q <= 8'h00;
      res_q <= 8'h00;
      skip_q <= 1'b0;
      nop_left_q <= 3'h0;
      last_cycles_q <= 2'h0;
      last_skip_q <= 1'b0;
      unknown_q <= 1'b0;
      mem_addr_q <= '0;
      idle_prev_q <= 1'b1;
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      state_q <= state_d;
      ir_q <= ir_d;
      two_word_q <= two_word_d;
      acc_q <= acc_d;
      flags_q <= flags_d;
      new_flags_q <= new_flags_d;
      bank_q <= bank_d;
      opnd_q <= opnd_d;
      res_q <= res_d;
      skip_q <= skip_d;
      nop_left_q <= nop_left_d;
      last_cycles_q <= last_cycles_d;
      last_skip_q <= last_skip_d;
      unknown_q <= unknown_d;
      mem_addr_q <= mem_addr_d;
      idle_prev_q <= idle_prev_d;
      prdata_out <= prdata_d;
      pready_out <= pready_d;
      pslverr_out <= pslverr_d;
      busy_out <= busy_d;
    end
  end

endmodule

// file: verif/cbd_exec_sva.sv
// Checker for the APB answer and execution timing of the execution block
`timescale 1ns/1ps
module cbd_exec_checker (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic busy_out
);
  logic [4:0] blen_q;
  logic [4:0] blen_d;
  logic mapped;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  assign mapped = (paddr_in[1:0] == 2'h0) && (paddr_in <= 8'h18);
  // Busy run length, judged at the edge where busy drops
  always_comb begin
    blen_d = busy_out ? blen_q + 5'h01 : 5'h00;
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      blen_q <= 5'h00;
    end else begin
      blen_q <= blen_d;
    end
  end
  a_ready_one_cycle: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  a_ready_after_access: assert property (pready_out |-> $past(psel_in && penable_in))
    else $error("ready without access phase");
  a_err_on_unmapped: assert property (pready_out |-> pslverr_out == !mapped)
    else $error("error flag wrong for address");
  a_err_only_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_rdata_quiet: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside answer");
  a_busy_four_phases: assert property ($rose(busy_out) |-> busy_out [*4])
    else $error("instruction cycle shorter than four clocks");
  a_busy_len_legal: assert property ($fell(busy_out) |-> blen_q inside {5'h04, 5'h08, 5'h0c})
    else $error("execution length not one, two or three cycles");
  a_idle_gap: assert property ($fell(busy_out) |-> !pready_out ##1 !pready_out)
    else $error("access answered too soon after execution");
  c_skip: cover property ($fell(busy_out) && blen_q == 5'h08);
  c_skip_two_word: cover property ($fell(busy_out) && blen_q == 5'h0c);
  c_unmapped: cover property (pready_out && pslverr_out);
endmodule

bind cbd_exec_top cbd_exec_checker i_chk (.clk_in(clk_in), .resetn_in(resetn_in),
  .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .busy_out(busy_out));

// file: verif/cbd_exec_tb_top.sv
// Random self-checking testbench for the execution block
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
    end \
  end
module cbd_exec_tb_top;
  import cbd_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic busy_out;
  logic [31:0] rd;
  logic err;
  logic [15:0] seed = 16'h005b;
  int fails = 0;
  int n_checks = 0;
  cbd_exec_top i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .busy_out(busy_out));
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // High digit judged after the low fix, whose carry runs into it
  function automatic logic [8:0] daw_exp(input logic [7:0] w, input logic c, input logic dc);
    logic [8:0] r;
    r = {1'b0, w};
    if (w[3:0] > 4'h9 || dc) r = r + 9'h006;
    if (r[7:4] > 4'h9 || c || r[8]) r = r + 9'h060;
    return r;
  endfunction
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1 && n < 100) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 100) begin
      fails++;
      wrap_up();
    end
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_in);
    fails++;
    wrap_up();
  end
  initial begin
    logic [7:0] acc, v, f, r, eacc, emem;
    logic [4:0] fl, efl;
    logic [3:0] bs;
    logic [11:0] ea, alt;
    logic [15:0] ins;
    logic [8:0] dw;
    logic a, d, tw, skip;
    int k;
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    for (int q = 0; q < 6; q++) begin
      apb(1'b0, 8'(q * 4), 32'h0);
      `CHK("reset value", 32'h0, rd)
    end
    apb(1'b0, 8'h1c, 32'h0);
    `CHK("unmapped", 33'h100000000, {err, rd})
    for (int i = 0; i < 60; i++) begin
      k = i % 6;
      seed = lfsr(seed);
      {tw, d, a, bs, acc} = seed[14:0];
      seed = lfsr(seed);
      {f, v} = seed;
      seed = lfsr(seed);
      fl = seed[4:0];
      case (i % 8)
        0: v = 8'h01;
        1: v = 8'h00;
        2: v = 8'h80;
        3: acc = v;
        4: v = 8'h10;
        default: ;
      endcase
      // Corner: the low fix pushes a high digit of nine past nine
      if (k == 1 && i % 12 == 7) acc = 8'h9a;
      ea = {a ? bs : 4'h0, f};
      alt = {a ? 4'h0 : bs, f};
      case (k)
        0: ins = {OP_COMPARE_SKIP_IF_LESS, a, f};
        1: ins = OP_DECIMAL_ADJUST;
        2: ins = {OP_DECREMENT_REGISTER, d, a, f};
        3: ins = {OP_DECREMENT_SKIP_IF_ZERO, d, a, f};
        4: ins = {OP_DECREMENT_SKIP_IF_NONZERO, d, a, f};
        default: ins = 16'h0008;
      endcase
      r = v - 8'h01;
      eacc = acc;
      emem = v;
      efl = fl;
      skip = (k == 0) ? v < acc : (k == 3) ? r == 8'h00 : (k == 4) ? r != 8'h00 : 1'b0;
      dw = daw_exp(acc, fl[0], fl[1]);
      if (k == 1) eacc = dw[7:0];
      if (k == 1) efl[0] = dw[8] | fl[0];
      if (k >= 2 && k <= 4 && d) emem = r;
      if (k >= 2 && k <= 4 && !d) eacc = r;
      if (k == 2) efl = {r[7], v == 8'h80, r == 8'h00, v[3:0] != 4'h0, v != 8'h00};
      apb(1'b1, BANK_SEL_OFS, {28'h0, bs});
      apb(1'b1, MEM_ADDR_OFS, {20'h0, alt});
      apb(1'b1, MEM_DATA_OFS, {24'h0, ~v});
      apb(1'b1, MEM_ADDR_OFS, {20'h0, ea});
      apb(1'b1, MEM_DATA_OFS, {24'h0, v});
      apb(1'b1, ACC_OFS, {24'h0, acc});
      apb(1'b1, FLAGS_OFS, {27'h0, fl});
      apb(1'b1, ISSUE_OFS, {15'h0, tw, ins});
      apb(1'b0, ISSUE_OFS, 32'h0);
      `CHK("issue", {15'h0, tw, ins}, rd)
      apb(1'b0, EXEC_STAT_OFS, 32'h0);
      `CHK("status", {1'b0, k == 5, skip, skip ? (tw ? 2'h3 : 2'h2) : 2'h1}, rd[4:0])
      apb(1'b0, ACC_OFS, 32'h0);
      `CHK("acc", eacc, rd[7:0])
      apb(1'b0, FLAGS_OFS, 32'h0);
      `CHK("flags", efl, rd[4:0])
      apb(1'b0, MEM_DATA_OFS, 32'h0);
      `CHK("mem", emem, rd[7:0])
      $display("test %0d kind %0d done", i, k);
    end
    wrap_up();
  end
endmodule
